// ### fdm_pkg.sv
// Shared constants and types of the flash data memory controller.
// Assumes both ends share one 50 MHz clock and one active-low reset.
package fdm_pkg;
  // --------------------------------------------------------------
  // Register offsets and values
  // --------------------------------------------------------------
  localparam logic [7:0] SFR_CMD = 8'hb9;
  localparam logic [7:0] SFR_BYTE1 = 8'hbc;
  localparam logic [7:0] SFR_BYTE2 = 8'hbd;
  localparam logic [7:0] SFR_BYTE3 = 8'hbe;
  localparam logic [7:0] SFR_BYTE4 = 8'hbf;
  localparam logic [7:0] SFR_PAGE = 8'hc6;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] UNMAPPED_VAL = 8'h00;
  localparam logic [7:0] VERIFY_OK = 8'h00;
  localparam logic [7:0] VERIFY_FAIL = 8'h01;
  // --------------------------------------------------------------
  // Commands
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_RSVD = 8'h03;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  // --------------------------------------------------------------
  // Data array geometry
  // --------------------------------------------------------------
  localparam int PAGES = 160;
  localparam logic [7:0] LAST_PAGE = 8'h9f;
  localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
  typedef enum logic [2:0] {
    MEM_NONE = 3'h0,
    MEM_PROG = 3'h1,
    MEM_ERASE = 3'h2,
    MEM_ERASE_ALL = 3'h3
  } mem_op_t;
  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int ERASE_TIME_MS = 2;
  localparam int PROG_TIME_US = 250;
  localparam int READ_CYCLES = 1;
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int CNT_W = 17;
  localparam logic [2:0] BOOT_WAIT = 3'h4;
  // --------------------------------------------------------------
  // Parallel programming pins
  // --------------------------------------------------------------
  localparam int PIN_W = 35;
  localparam int PIN_P0 = 0;
  localparam int PIN_P1 = 8;
  localparam int PIN_P2 = 16;
  localparam int PIN_P3 = 24;
  localparam int PIN_STROBE_N = 32;
  localparam int PIN_ALE = 33;
  localparam int PIN_PROG = 34;
  localparam int P3_OP_LSB = 1;
  localparam int P3_SPACE_BIT = 4;
  localparam logic [2:0] PP_ERASE_ALL = 3'h0;
  localparam logic [2:0] PP_SIG = 3'h1;
  localparam logic [2:0] PP_PROG = 3'h2;
  localparam logic [2:0] PP_READ = 3'h3;
  localparam logic [2:0] PP_PROG_SEC = 3'h4;
  localparam logic [2:0] PP_VER_SEC = 3'h5;
  localparam int SEC_LOCK = 0;
  localparam int SEC_SECURE = 1;
  localparam int SEC_SAFE = 2;
  // --------------------------------------------------------------
  // States
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_BUSY = 2'h2
  } dev_state_t;
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_ISSUE = 3'h2,
    CS_WAIT = 3'h4
  } core_state_t;
endpackage

// ### fdm_if.sv
// Register bus between the core and the flash data memory controller.
// Assumes both parties run on the same clock; no clocking here.
`timescale 1ns/1ps
interface fdm_if;
  logic [7:0] sfr_addr;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic stall;
  logic irq_hold;
  logic ctr_ext;
  logic ctr_block;

  modport device (
    input sfr_addr, sfr_wr, sfr_rd, sfr_wdata, ctr_ext,
    output sfr_rdata, stall, irq_hold, ctr_block
  );
  modport core (
    output sfr_addr, sfr_wr, sfr_rd, sfr_wdata, ctr_ext,
    input sfr_rdata, stall, irq_hold, ctr_block
  );
endinterface

// ### fdm_data_array.sv
// Page-organised nonvolatile data array, one word per four-byte page.
// Assumes one operation per cycle; contents have no reset.
`timescale 1ns/1ps
module fdm_data_array (
  input wire logic clk_i,
  input wire fdm_pkg::mem_op_t op_i,
  input wire logic [7:0] wr_page_i,
  input wire logic [31:0] wr_word_i,
  input wire logic [7:0] rd_page_i,
  output logic [31:0] rd_word_o
);
  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [31:0] mem [fdm_pkg::PAGES];

  // Programming can only clear bits, as in the real cells
  always_ff @(posedge clk_i)
  begin
    case (op_i)
      fdm_pkg::MEM_PROG:
        if (wr_page_i <= fdm_pkg::LAST_PAGE)
          mem[wr_page_i] <= mem[wr_page_i] & wr_word_i;
      fdm_pkg::MEM_ERASE:
        if (wr_page_i <= fdm_pkg::LAST_PAGE)
          mem[wr_page_i] <= fdm_pkg::ERASED_WORD;
      fdm_pkg::MEM_ERASE_ALL:
        for (int i = 0; i < fdm_pkg::PAGES; i++)
          mem[i] <= fdm_pkg::ERASED_WORD;
      default:
        ;
    endcase
  end

  // Out-of-range pages read as erased
  assign rd_word_o = (rd_page_i <= fdm_pkg::LAST_PAGE) ? mem[rd_page_i] : fdm_pkg::ERASED_WORD;
endmodule

// ### fdm_device.sv
// Flash data memory controller, device end: registers, command sequencer,
// parallel programming decode, security modes and download entry.
// Assumes the core end on the interface and pins from outside the domain.
`timescale 1ns/1ps
module fdm_device #(
  parameter int ERASE_CYCLES = fdm_pkg::ERASE_CYCLES,
  parameter int PROG_CYCLES = fdm_pkg::PROG_CYCLES,
  // Signature value is arbitrary
  parameter logic [7:0] SIGNATURE = 8'h5a
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  fdm_if.device bus,
  input wire logic prog_mode_i,
  input wire logic ale_i,
  input wire logic code_fetch_strobe_n_i,
  input wire logic [7:0] port0_i,
  input wire logic [7:0] port1_i,
  input wire logic [7:0] port2_i,
  input wire logic [7:0] port3_i,
  input wire logic [2:0] security_init_i,
  input wire logic serial_code_erase_i,
  input wire logic [7:0] code_rdata_i,
  output logic [7:0] port0_o,
  output logic port0_oe_o,
  output logic code_wr_o,
  output logic code_erase_o,
  output logic [15:0] code_addr_o,
  output logic [7:0] code_wdata_o,
  output logic download_mode_o,
  output logic [2:0] security_o
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  localparam int CW = fdm_pkg::CNT_W;
  localparam logic [CW-1:0] ERASE_LOAD = CW'(ERASE_CYCLES - 1);
  localparam logic [CW-1:0] PROG_LOAD = CW'(PROG_CYCLES - 1);
  localparam logic [CW-1:0] READ_LOAD = CW'(fdm_pkg::READ_CYCLES - 1);

  typedef struct packed {
    fdm_pkg::dev_state_t st;
    logic [7:0] cmd;
    logic [7:0] page;
    logic [3:0][7:0] data;
    logic [CW-1:0] cnt;
    logic [7:0] rdata;
    logic stall;
    logic ctr_block;
    logic [fdm_pkg::PIN_W-1:0] s1;
    logic [fdm_pkg::PIN_W-1:0] s2;
    logic [fdm_pkg::PIN_W-1:0] s3;
    logic [fdm_pkg::PIN_W-1:0] pin;
    logic ale_prev;
    logic [7:0] p0_out;
    logic p0_oe;
    logic [2:0] sec;
    logic [2:0] boot_cnt;
    logic booted;
    logic download;
    logic code_wr;
    logic code_erase;
    logic [15:0] code_addr;
    logic [7:0] code_wdata;
  } dev_reg_t;

  localparam dev_reg_t RESET_STATE = '{st: fdm_pkg::ST_IDLE, default: '0};

  dev_reg_t q;
  dev_reg_t d;
  logic [fdm_pkg::PIN_W-1:0] pins_raw;
  fdm_pkg::mem_op_t mem_op;
  logic [7:0] mem_page;
  logic [31:0] mem_word;
  logic [7:0] rd_page;
  logic [3:0][7:0] rd_word;
  logic ale_rise;
  logic pp_on;
  logic [15:0] pp_addr;
  logic [2:0] pp_op;
  logic pp_code;
  logic [7:0] pp_din;

  function automatic logic [7:0] sfr_read(input logic [7:0] a, input dev_reg_t r);
    logic [7:0] v;
    v = fdm_pkg::UNMAPPED_VAL;
    case (a)
      fdm_pkg::SFR_CMD: v = r.cmd;
      fdm_pkg::SFR_BYTE1: v = r.data[0];
      fdm_pkg::SFR_BYTE2: v = r.data[1];
      fdm_pkg::SFR_BYTE3: v = r.data[2];
      fdm_pkg::SFR_BYTE4: v = r.data[3];
      fdm_pkg::SFR_PAGE: v = r.page;
      default: v = fdm_pkg::UNMAPPED_VAL;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] byte_word(input logic [1:0] sel, input logic [7:0] b);
    logic [3:0][7:0] w;
    w = fdm_pkg::ERASED_WORD;
    w[sel] = b;
    return w;
  endfunction

  // --------------------------------------------------------------
  // Data array
  // --------------------------------------------------------------
  fdm_data_array fdm_data_array_i (
    .clk_i(clk_i),
    .op_i(mem_op),
    .wr_page_i(mem_page),
    .wr_word_i(mem_word),
    .rd_page_i(rd_page),
    .rd_word_o(rd_word)
  );

  assign pins_raw = {prog_mode_i, ale_i, code_fetch_strobe_n_i,
                     port3_i, port2_i, port1_i, port0_i};
  assign ale_rise = q.pin[fdm_pkg::PIN_ALE] & ~q.ale_prev;
  assign pp_on = q.booted & q.pin[fdm_pkg::PIN_PROG];
  assign pp_addr = {q.pin[fdm_pkg::PIN_P2 +: 8], q.pin[fdm_pkg::PIN_P1 +: 8]};
  assign pp_op = q.pin[fdm_pkg::PIN_P3 + fdm_pkg::P3_OP_LSB +: 3];
  assign pp_code = q.pin[fdm_pkg::PIN_P3 + fdm_pkg::P3_SPACE_BIT];
  assign pp_din = q.pin[fdm_pkg::PIN_P0 +: 8];

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    d = q;
    mem_op = fdm_pkg::MEM_NONE;
    mem_page = q.page;
    mem_word = q.data;
    rd_page = pp_on ? pp_addr[9:2] : q.page;
    d.code_wr = 1'b0;
    d.code_erase = 1'b0;
    d.code_addr = pp_addr;
    d.code_wdata = pp_din;
    d.ale_prev = q.pin[fdm_pkg::PIN_ALE];
    // Three-stage sampling; a bit changes once stages two and three agree
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pin = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);
    d.ctr_block = q.sec[fdm_pkg::SEC_SECURE] & bus.ctr_ext;
    if (!pp_on)
      d.p0_oe = 1'b0;

    // Wait for the sampled strobe to settle before deciding on download
    if (!q.booted)
    begin
      if (q.boot_cnt == fdm_pkg::BOOT_WAIT)
      begin
        d.booted = 1'b1;
        d.sec = security_init_i;
        d.download = ~q.pin[fdm_pkg::PIN_STROBE_N]
                     & ~security_init_i[fdm_pkg::SEC_SAFE];
      end
      else
        d.boot_cnt = q.boot_cnt + 3'h1;
    end

    // Serial code-erase leaves serial-safe alone
    if (q.download && serial_code_erase_i)
    begin
      d.sec[fdm_pkg::SEC_LOCK] = 1'b0;
      d.sec[fdm_pkg::SEC_SECURE] = 1'b0;
    end

    // Parallel programming, one operation per strobe
    if (pp_on && ale_rise && q.st == fdm_pkg::ST_IDLE)
    begin
      d.p0_oe = 1'b0;
      case (pp_op)
        fdm_pkg::PP_ERASE_ALL:
        begin
          d.sec = '0;
          d.code_erase = 1'b1;
          mem_op = fdm_pkg::MEM_ERASE_ALL;
        end
        fdm_pkg::PP_SIG:
        begin
          d.p0_out = SIGNATURE;
          d.p0_oe = 1'b1;
        end
        fdm_pkg::PP_PROG:
          if (pp_code)
            d.code_wr = ~q.sec[fdm_pkg::SEC_LOCK] & ~q.sec[fdm_pkg::SEC_SECURE];
          else
          begin
            mem_op = fdm_pkg::MEM_PROG;
            mem_page = pp_addr[9:2];
            mem_word = byte_word(pp_addr[1:0], pp_din);
          end
        fdm_pkg::PP_READ:
          if (pp_code)
          begin
            d.p0_out = code_rdata_i;
            d.p0_oe = ~q.sec[fdm_pkg::SEC_SECURE];
          end
          else
          begin
            d.p0_out = rd_word[pp_addr[1:0]];
            d.p0_oe = 1'b1;
          end
        fdm_pkg::PP_PROG_SEC:
          d.sec = q.sec | pp_din[2:0];
        fdm_pkg::PP_VER_SEC:
        begin
          d.p0_out = {5'h00, q.sec};
          d.p0_oe = 1'b1;
        end
        default:
          ;
      endcase
    end

    // Core register access
    if (bus.sfr_rd)
      d.rdata = sfr_read(bus.sfr_addr, q);
    case (q.st)
      fdm_pkg::ST_IDLE:
        if (bus.sfr_wr && !pp_on)
        begin
          case (bus.sfr_addr)
            fdm_pkg::SFR_PAGE: d.page = bus.sfr_wdata;
            fdm_pkg::SFR_BYTE1: d.data[0] = bus.sfr_wdata;
            fdm_pkg::SFR_BYTE2: d.data[1] = bus.sfr_wdata;
            fdm_pkg::SFR_BYTE3: d.data[2] = bus.sfr_wdata;
            fdm_pkg::SFR_BYTE4: d.data[3] = bus.sfr_wdata;
            fdm_pkg::SFR_CMD:
            begin
              d.cmd = bus.sfr_wdata;
              // Reserved codes are stored but start nothing
              d.st = fdm_pkg::ST_BUSY;
              d.stall = 1'b1;
              case (bus.sfr_wdata)
                fdm_pkg::CMD_READ: d.cnt = READ_LOAD;
                fdm_pkg::CMD_VERIFY: d.cnt = READ_LOAD;
                fdm_pkg::CMD_PROG: d.cnt = PROG_LOAD;
                fdm_pkg::CMD_ERASE: d.cnt = ERASE_LOAD;
                fdm_pkg::CMD_ERASE_ALL: d.cnt = ERASE_LOAD;
                default:
                begin
                  d.st = fdm_pkg::ST_IDLE;
                  d.stall = 1'b0;
                end
              endcase
            end
            default:
              ;
          endcase
        end
      fdm_pkg::ST_BUSY:
        if (q.cnt == '0)
        begin
          d.st = fdm_pkg::ST_IDLE;
          d.stall = 1'b0;
          case (q.cmd)
            fdm_pkg::CMD_READ: d.data = rd_word;
            fdm_pkg::CMD_PROG: mem_op = fdm_pkg::MEM_PROG;
            fdm_pkg::CMD_VERIFY:
              d.cmd = (rd_word == q.data) ? fdm_pkg::VERIFY_OK : fdm_pkg::VERIFY_FAIL;
            fdm_pkg::CMD_ERASE: mem_op = fdm_pkg::MEM_ERASE;
            fdm_pkg::CMD_ERASE_ALL: mem_op = fdm_pkg::MEM_ERASE_ALL;
            default:
              ;
          endcase
        end
        else
          d.cnt = q.cnt - CW'(1);
      default:
        d.st = fdm_pkg::ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // Registers and outputs
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= RESET_STATE;
    else
      q <= d;
  end

  // Instruction flow and interrupts stop; timers elsewhere keep running
  assign bus.stall = q.stall;
  assign bus.irq_hold = q.stall;
  assign bus.sfr_rdata = q.rdata;
  assign bus.ctr_block = q.ctr_block;
  assign port0_o = q.p0_out;
  assign port0_oe_o = q.p0_oe;
  assign code_wr_o = q.code_wr;
  assign code_erase_o = q.code_erase;
  assign code_addr_o = q.code_addr;
  assign code_wdata_o = q.code_wdata;
  assign download_mode_o = q.download;
  assign security_o = q.sec;
endmodule

// ### fdm_core_end.sv
// Core end of the flash data memory register bus: one access at a time,
// held off while the device stalls the core.
// Assumes the device end on the interface and a same-clock requester.
`timescale 1ns/1ps
module fdm_core_end (
  input wire logic clk_i,
  input wire logic arst_n_i,
  fdm_if.core bus,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic ctr_ext_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] rdata_o,
  output logic stalled_o,
  output logic irq_hold_o,
  output logic ctr_block_o
);
  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    fdm_pkg::core_state_t st;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic ctr_ext;
    logic ready;
    logic done;
    logic [7:0] rdata;
    logic stalled;
    logic irq_hold;
    logic ctr_block;
  } core_reg_t;

  localparam core_reg_t RESET_STATE = '{st: fdm_pkg::CS_IDLE, ready: 1'b1, default: '0};

  core_reg_t q;
  core_reg_t d;

  always_comb
  begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.done = 1'b0;
    d.ctr_ext = ctr_ext_i;
    d.stalled = bus.stall;
    d.irq_hold = bus.irq_hold;
    d.ctr_block = bus.ctr_block;
    case (q.st)
      fdm_pkg::CS_IDLE:
        if (req_i)
        begin
          d.addr = addr_i;
          d.wdata = wdata_i;
          d.wr = we_i;
          d.rd = ~we_i;
          d.ready = 1'b0;
          d.st = fdm_pkg::CS_ISSUE;
        end
      fdm_pkg::CS_ISSUE:
        d.st = fdm_pkg::CS_WAIT;
      fdm_pkg::CS_WAIT:
        // No further access until the command has finished
        if (!bus.stall)
        begin
          d.rdata = bus.sfr_rdata;
          d.done = 1'b1;
          d.ready = 1'b1;
          d.st = fdm_pkg::CS_IDLE;
        end
      default:
        d.st = fdm_pkg::CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      q <= RESET_STATE;
    else
      q <= d;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign bus.sfr_addr = q.addr;
  assign bus.sfr_wdata = q.wdata;
  assign bus.sfr_wr = q.wr;
  assign bus.sfr_rd = q.rd;
  assign bus.ctr_ext = q.ctr_ext;
  assign ready_o = q.ready;
  assign done_o = q.done;
  assign rdata_o = q.rdata;
  assign stalled_o = q.stalled;
  assign irq_hold_o = q.irq_hold;
  assign ctr_block_o = q.ctr_block;
endmodule

// ### fdm_checker.sv
// Concurrent checks on the register bus between the core end and device.
// Assumes one clock, one reset and the bus signals wired in as inputs.
`timescale 1ns/1ps
module fdm_checker #(
  parameter int ERASE_CYCLES = 20,
  parameter int PROG_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic stall,
  input wire logic irq_hold,
  input wire logic ctr_ext,
  input wire logic ctr_block
);
  // ----
  // Helper state
  // ----
  logic [17:0] cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] page_q;
  int exp_n;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  always_comb
  begin
    case (cmd_q)
      fdm_pkg::CMD_PROG: exp_n = PROG_CYCLES;
      fdm_pkg::CMD_ERASE, fdm_pkg::CMD_ERASE_ALL: exp_n = ERASE_CYCLES;
      default: exp_n = 1;
    endcase
  end
  // Stall length counted here: a repetition that long would not unroll
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_q <= '0;
      cmd_q <= '0;
      page_q <= '0;
    end
    else
    begin
      cnt_q <= stall ? cnt_q + 18'h1 : '0;
      if (sfr_wr && !stall && sfr_addr == fdm_pkg::SFR_CMD)
        cmd_q <= sfr_wdata;
      if (sfr_wr && !stall && sfr_addr == fdm_pkg::SFR_PAGE)
        page_q <= sfr_wdata;
    end
  end
  // ----
  // Properties
  // ----
  sequence s_cmd(logic [7:0] c);
    sfr_wr && !stall && sfr_addr == fdm_pkg::SFR_CMD && sfr_wdata == c;
  endsequence
  sequence s_blip;
    stall ##1 !stall;
  endsequence
  property p_read_time;
    s_cmd(fdm_pkg::CMD_READ) |=> s_blip;
  endproperty
  a_read_time: assert property (p_read_time) else $error("read stall wrong");
  property p_verify_time;
    s_cmd(fdm_pkg::CMD_VERIFY) |=> s_blip;
  endproperty
  a_verify_time: assert property (p_verify_time) else $error("verify stall wrong");
  property p_op_time;
    $fell(stall) |-> cnt_q == 18'(exp_n);
  endproperty
  a_op_time: assert property (p_op_time) else $error("stall length wrong");
  property p_prog_start;
    s_cmd(fdm_pkg::CMD_PROG) |=> stall [*2];
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program not started");
  property p_erase_start;
    s_cmd(fdm_pkg::CMD_ERASE_ALL) |=> stall [*2];
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase not started");
  property p_rsvd;
    sfr_wr && !stall && sfr_addr == fdm_pkg::SFR_CMD
      && (sfr_wdata == fdm_pkg::CMD_RSVD || sfr_wdata > fdm_pkg::CMD_ERASE_ALL)
      |=> !stall [*2];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved command stalled");
  property p_cause;
    $rose(stall) |-> $past(sfr_wr) && $past(sfr_addr) == fdm_pkg::SFR_CMD;
  endproperty
  a_cause: assert property (p_cause) else $error("stall without command");
  property p_irq;
    irq_hold == stall;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt hold differs");
  property p_page_rd;
    sfr_rd && sfr_addr == fdm_pkg::SFR_PAGE |=> sfr_rdata == page_q;
  endproperty
  a_page_rd: assert property (p_page_rd) else $error("page pointer read wrong");
  property p_hold;
    !sfr_rd |=> $stable(sfr_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_ctr;
    !ctr_ext |=> !ctr_block;
  endproperty
  a_ctr: assert property (p_ctr) else $error("table read blocked");
endmodule

// ### flash_data_memory_controller_bench.sv
// Testbench of both ends of the flash data memory register bus.
// Assumes the package, interface, device, core end and checker compiled first.
`timescale 1ns/1ps
module flash_data_memory_controller_bench;
  // Short counts keep the run brief; expectations follow them
  localparam int ERASE_N = 20;
  localparam int PROG_N = 10;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic req_i = 1'b0, we_i = 1'b0, ctr_ext_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, port0_o;
  logic ready_o, done_o, stalled_o, irq_hold_o, ctr_block_o;
  logic prog_mode_i = 1'b0, ale_i = 1'b0, strobe_n = 1'b1, erase_seen = 1'b0;
  logic wr_seen = 1'b0, ser_erase = 1'b0, code_wr_o;
  logic [7:0] port3_i = 8'h00;
  logic [2:0] sec_init = 3'h0, security_o;
  logic port0_oe_o, code_erase_o, download_mode_o;
  int n_mismatch = 0;
  int n_tests = 0;
  fdm_if fdm_if_i ();
  fdm_device #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) fdm_device_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .bus(fdm_if_i), .prog_mode_i(prog_mode_i),
    .ale_i(ale_i), .code_fetch_strobe_n_i(strobe_n), .port0_i(8'h00), .port1_i(8'h00),
    .port2_i(8'h00), .port3_i(port3_i), .security_init_i(sec_init),
    .serial_code_erase_i(ser_erase), .code_rdata_i(8'h00), .port0_o(port0_o),
    .port0_oe_o(port0_oe_o), .code_wr_o(code_wr_o), .code_erase_o(code_erase_o),
    .code_addr_o(), .code_wdata_o(), .download_mode_o(download_mode_o),
    .security_o(security_o));
  fdm_core_end fdm_core_end_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(fdm_if_i),
    .req_i(req_i), .we_i(we_i), .addr_i(addr_i), .wdata_i(wdata_i), .ctr_ext_i(ctr_ext_i),
    .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .stalled_o(stalled_o),
    .irq_hold_o(irq_hold_o), .ctr_block_o(ctr_block_o));
  fdm_checker #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) fdm_checker_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .sfr_addr(fdm_if_i.sfr_addr),
    .sfr_wr(fdm_if_i.sfr_wr), .sfr_rd(fdm_if_i.sfr_rd), .sfr_wdata(fdm_if_i.sfr_wdata),
    .sfr_rdata(fdm_if_i.sfr_rdata), .stall(fdm_if_i.stall), .irq_hold(fdm_if_i.irq_hold),
    .ctr_ext(fdm_if_i.ctr_ext), .ctr_block(fdm_if_i.ctr_block));
  always #10 clk_i = ~clk_i;
  // Code erase and code write are one-cycle pulses, so they are latched here
  always @(posedge clk_i)
  begin
    if (code_erase_o === 1'b1)
      erase_seen <= 1'b1;
    if (code_wr_o === 1'b1)
      wr_seen <= 1'b1;
  end
  // ----
  // Shared tasks
  // ----
  task automatic summarize();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output int n);
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1)
    begin
      @(negedge clk_i);
      n++;
      if (n > 200)
      begin
        chk(8'h00, 8'h01);
        summarize();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    acc(1'b1, a, d, n);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    acc(1'b0, a, 8'h00, n);
    chk(rdata_o, exp);
  endtask
  // Access time = 2 cycles after the taking edge plus the stall
  task automatic cmd(input logic [7:0] c, input int stall_n);
    int n;
    acc(1'b1, fdm_pkg::SFR_CMD, c, n);
    chk(8'(n), 8'(2 + stall_n));
  endtask
  task automatic set_w(input logic [31:0] w);
    wr(fdm_pkg::SFR_BYTE1, w[7:0]);
    wr(fdm_pkg::SFR_BYTE2, w[15:8]);
    wr(fdm_pkg::SFR_BYTE3, w[23:16]);
    wr(fdm_pkg::SFR_BYTE4, w[31:24]);
  endtask
  task automatic chk_w(input logic [31:0] w);
    rd(fdm_pkg::SFR_BYTE1, w[7:0]);
    rd(fdm_pkg::SFR_BYTE2, w[15:8]);
    rd(fdm_pkg::SFR_BYTE3, w[23:16]);
    rd(fdm_pkg::SFR_BYTE4, w[31:24]);
  endtask
  task automatic boot(input logic s_n, input logic [2:0] sec);
    @(negedge clk_i);
    arst_n_i = 1'b0;
    strobe_n = s_n;
    sec_init = sec;
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask
  // Pins change long before and after the strobe: they cross four flops
  task automatic par(input logic [7:0] p3);
    port3_i = p3;
    repeat (6) @(negedge clk_i);
    ale_i = 1'b1;
    repeat (8) @(negedge clk_i);
    ale_i = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    logic [7:0] a [7];
    a = '{fdm_pkg::SFR_CMD, fdm_pkg::SFR_BYTE1, fdm_pkg::SFR_BYTE2, fdm_pkg::SFR_BYTE3,
      fdm_pkg::SFR_BYTE4, fdm_pkg::SFR_PAGE, 8'h80};
    foreach (a[i])
      rd(a[i], 8'h00);
  endtask
  task automatic t_data();
    logic [7:0] r [3];
    r = '{8'h07, 8'h80, 8'hff};
    wr(fdm_pkg::SFR_PAGE, fdm_pkg::LAST_PAGE);
    cmd(fdm_pkg::CMD_ERASE_ALL, ERASE_N);
    cmd(fdm_pkg::CMD_READ, 1);
    chk_w(fdm_pkg::ERASED_WORD);
    set_w(32'h4433_2211);
    cmd(fdm_pkg::CMD_PROG, PROG_N);
    wr(fdm_pkg::SFR_PAGE, 8'h9e);
    set_w(32'h8877_6655);
    cmd(fdm_pkg::CMD_PROG, PROG_N);
    set_w(32'h0000_0000);
    wr(fdm_pkg::SFR_PAGE, fdm_pkg::LAST_PAGE);
    cmd(fdm_pkg::CMD_READ, 1);
    chk_w(32'h4433_2211);
    cmd(fdm_pkg::CMD_VERIFY, 1);
    rd(fdm_pkg::SFR_CMD, fdm_pkg::VERIFY_OK);
    wr(fdm_pkg::SFR_BYTE1, 8'h10);
    cmd(fdm_pkg::CMD_VERIFY, 1);
    rd(fdm_pkg::SFR_CMD, fdm_pkg::VERIFY_FAIL);
    cmd(fdm_pkg::CMD_ERASE, ERASE_N);
    chk_w(32'h4433_2210);
    cmd(fdm_pkg::CMD_READ, 1);
    chk_w(fdm_pkg::ERASED_WORD);
    wr(fdm_pkg::SFR_PAGE, 8'h9e);
    cmd(fdm_pkg::CMD_READ, 1);
    chk_w(32'h8877_6655);
    wr(fdm_pkg::SFR_BYTE2, 8'hf3);
    cmd(fdm_pkg::CMD_ERASE, ERASE_N);
    cmd(fdm_pkg::CMD_PROG, PROG_N);
    cmd(fdm_pkg::CMD_READ, 1);
    chk_w(32'h8877_f355);
    foreach (r[i])
      cmd(r[i], 0);
    chk_w(32'h8877_f355);
  endtask
  task automatic t_secure();
    boot(1'b0, 3'h7);
    chk({7'h0, download_mode_o}, 8'h00);
    chk({5'h0, security_o}, 8'h07);
    ctr_ext_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({7'h0, ctr_block_o}, 8'h01);
    ctr_ext_i = 1'b0;
    prog_mode_i = 1'b1;
    par(8'h16);
    chk({7'h0, port0_oe_o}, 8'h00);
    par(8'h06);
    chk({7'h0, port0_oe_o}, 8'h01);
    chk(port0_o, 8'hff);
    par(8'h0a);
    chk(port0_o, 8'h07);
    par(8'h14);
    chk({7'h0, wr_seen}, 8'h00);
    par(8'h00);
    chk({5'h0, security_o}, 8'h00);
    chk({7'h0, erase_seen}, 8'h01);
    par(8'h14);
    chk({7'h0, wr_seen}, 8'h01);
    prog_mode_i = 1'b0;
  endtask
  initial
  begin
    boot(1'b1, 3'h0);
    t_regs();
    t_data();
    boot(1'b0, 3'h3);
    chk({7'h0, download_mode_o}, 8'h01);
    ser_erase = 1'b1;
    @(negedge clk_i);
    ser_erase = 1'b0;
    @(negedge clk_i);
    chk({5'h0, security_o}, 8'h00);
    t_secure();
    summarize();
  end
endmodule
